// ---- hdl/alf_pkg.sv ----
// Shared constants, modes and carriers for the look-ahead stream buffer
package alf_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_INT_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_MASK = 8'h08;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_THR_HIGH_BIT = 2;
    localparam int STAT_THR_LOW_BIT = 3;
    localparam int STAT_OCC_LSB = 8;

    // ------------------------------------------------------------------
    // Interrupt events, status and mask share this layout
    // ------------------------------------------------------------------
    localparam int INT_W = 4;
    localparam int EV_THR_HIGH = 0;
    localparam int EV_THR_LOW = 1;
    localparam int EV_WR_STALL = 2;
    localparam int EV_DRAINED = 3;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    localparam logic [3:0] INT_STATUS_RST = 4'h0;

    // ------------------------------------------------------------------
    // Defaults and limits of the stream word and storage, and the user field width
    // ------------------------------------------------------------------
    localparam int DATA_W_DEF = 32;
    localparam int DEPTH_DEF = 512;
    localparam int DATA_W_MAX = 4096;
    localparam int DEPTH_MAX = 131072;
    localparam int USER_W = 8;

    typedef enum {
        ALF_FULL_BUFFER,
        ALF_REG_STAGE,
        ALF_PASS_THROUGH
    } alf_mode_e;

    typedef enum {
        ALF_THR_CONST,
        ALF_THR_PORT
    } alf_thr_src_e;

    // Sideband carried with every data word
    typedef struct packed {
        logic last;
        logic [USER_W-1:0] user;
    } alf_side_s;

    localparam int SIDE_W = $bits(alf_side_s);

    // One register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } alf_bus_req_s;

endpackage : alf_pkg

// ---- hdl/alf_stream_fifo.sv ----
// Look-ahead stream buffer with valid/ready on both sides and a register port
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - A word moves only when valid and ready are both high at the edge.
// - Senders raise valid for usable words; receivers raise ready when able to take.
// - Write-side ready stays high while a free slot remains.
// - Read-side valid stays high while any stored word remains.
// - All carried signals pack into one stored word and come out unchanged.
// - Oldest word appears on the output with valid without any read request.
// - One asynchronous active-low reset, always passed through reset-safety handling.
// - Stream data width is a parameter from 1 to 4096 bits.
// - Storage depth is a parameter up to 131072 entries.
// - One clock shared by both sides; no cross-domain state to synchronize.
// - Build choice: full buffer, single register stage, or pass-through.
// - Optional threshold high and low flags, level from constant or port.
module alf_stream_fifo #(
    parameter int DATA_W = alf_pkg::DATA_W_DEF,
    parameter int DEPTH = alf_pkg::DEPTH_DEF,
    parameter alf_pkg::alf_mode_e MODE = alf_pkg::ALF_FULL_BUFFER,
    parameter alf_pkg::alf_thr_src_e THR_SRC = alf_pkg::ALF_THR_CONST,
    parameter int THR_HIGH_C = alf_pkg::DEPTH_DEF - 1,
    parameter int THR_LOW_C = 1,
    localparam int OCC_W = $clog2(DEPTH + 2)
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [DATA_W-1:0] s_data,
    input wire alf_pkg::alf_side_s s_side,
    output logic m_valid,
    input wire logic m_ready,
    output logic [DATA_W-1:0] m_data,
    output alf_pkg::alf_side_s m_side,
    input wire logic [OCC_W-1:0] thr_high_in,
    input wire logic [OCC_W-1:0] thr_low_in,
    output logic threshold_high_flag,
    output logic threshold_low_flag,
    input wire alf_pkg::alf_bus_req_s bus_req,
    output logic [31:0] bus_rdata,
    output logic irq
);
    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    // structure choice
    localparam int MEM_D = (MODE == alf_pkg::ALF_REG_STAGE) ? 1 : DEPTH;
    localparam int PTR_W = (MEM_D > 1) ? $clog2(MEM_D) : 1;
    localparam int CNT_W = $clog2(MEM_D + 1);
    localparam int WORD_W = DATA_W + alf_pkg::SIDE_W;
    localparam bit STORE = (MODE != alf_pkg::ALF_PASS_THROUGH);
    localparam logic [CNT_W-1:0] MEM_FULL = CNT_W'(MEM_D);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(MEM_D - 1);

    initial begin
        if (DATA_W < 1 || DATA_W > alf_pkg::DATA_W_MAX) begin
            $error("stream data width out of range");
        end
        if (DEPTH < 1 || DEPTH > alf_pkg::DEPTH_MAX) begin
            $error("storage depth out of range");
        end
    end

    function automatic logic [PTR_W-1:0] alf_ptr_inc(input logic [PTR_W-1:0] p);
        alf_ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_W'(1);
    endfunction : alf_ptr_inc

    // ------------------------------------------------------------------
    // Reset-safety synchroniser
    // ------------------------------------------------------------------
    // Assertion is immediate; release is held off two edges so no flop
    // leaves reset on a different edge from its neighbours.
    logic run_ff1_reg;
    logic run_n;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_ff1_reg <= 1'b0;
            run_n <= 1'b0;
        end else begin
            run_ff1_reg <= 1'b1;
            run_n <= run_ff1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Storage and look-ahead output stage
    // ------------------------------------------------------------------
    // one shared clock
    // Single clock only: both sides share one domain, so no pointer crossing.
    logic [WORD_W-1:0] mem [MEM_D];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] mem_cnt_reg;
    logic [CNT_W-1:0] mem_cnt_next;
    logic s_ready_reg;
    logic m_valid_reg;
    logic [WORD_W-1:0] m_word_reg;
    logic push;
    logic pop_mem;
    logic take;
    logic [OCC_W-1:0] occ_reg;
    logic [OCC_W-1:0] occ_next;
    logic [WORD_W-1:0] s_word;

    assign s_word = {s_side, s_data};
    // transfer on both high
    // Pass-through keeps storage idle so occupancy stays zero
    assign push = STORE & s_valid & s_ready_reg;
    assign take = m_valid_reg & m_ready;
    assign pop_mem = (mem_cnt_reg != '0) && (!m_valid_reg || m_ready);
    // push and pop in one cycle
    assign mem_cnt_next = mem_cnt_reg + CNT_W'(push) - CNT_W'(pop_mem);
    assign occ_next = OCC_W'(mem_cnt_next) + OCC_W'(pop_mem | (m_valid_reg & ~m_ready));

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= s_word;
        end
    end

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            mem_cnt_reg <= '0;
            occ_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= alf_ptr_inc(wr_ptr_reg);
            end
            if (pop_mem) begin
                rd_ptr_reg <= alf_ptr_inc(rd_ptr_reg);
            end
            mem_cnt_reg <= mem_cnt_next;
            occ_reg <= occ_next;
        end
    end

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            s_ready_reg <= 1'b0;
        end else begin
            s_ready_reg <= (mem_cnt_next != MEM_FULL);
        end
    end

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            m_valid_reg <= 1'b0;
            m_word_reg <= '0;
        end else if (pop_mem) begin
            m_valid_reg <= 1'b1;
            m_word_reg <= mem[rd_ptr_reg];
        end else if (take) begin
            m_valid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Output selection by structure
    // ------------------------------------------------------------------
    generate
        if (MODE == alf_pkg::ALF_PASS_THROUGH) begin : g_wire
            // Pass-through is combinational by definition; still gated by reset
            assign s_ready = m_ready & run_n;
            assign m_valid = s_valid & run_n;
            assign m_data = s_data;
            assign m_side = s_side;
        end else begin : g_store
            assign s_ready = s_ready_reg;
            assign m_valid = m_valid_reg;
            assign {m_side, m_data} = m_word_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Threshold flags
    // ------------------------------------------------------------------
    logic [OCC_W-1:0] thr_high_val;
    logic [OCC_W-1:0] thr_low_val;
    logic thr_high_reg;
    logic thr_low_reg;

    assign thr_high_val = (THR_SRC == alf_pkg::ALF_THR_PORT) ? thr_high_in : OCC_W'(THR_HIGH_C);
    assign thr_low_val = (THR_SRC == alf_pkg::ALF_THR_PORT) ? thr_low_in : OCC_W'(THR_LOW_C);

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            thr_high_reg <= 1'b0;
            thr_low_reg <= 1'b0;
        end else begin
            thr_high_reg <= (occ_next >= thr_high_val);
            thr_low_reg <= (occ_next <= thr_low_val);
        end
    end

    assign threshold_high_flag = thr_high_reg;
    assign threshold_low_flag = thr_low_reg;

    // ------------------------------------------------------------------
    // Register port and interrupts
    // ------------------------------------------------------------------
    logic [alf_pkg::INT_W-1:0] int_status_reg;
    logic [alf_pkg::INT_W-1:0] int_status_next;
    logic [alf_pkg::INT_W-1:0] int_mask_reg;
    logic [alf_pkg::INT_W-1:0] int_mask_next;
    logic [alf_pkg::INT_W-1:0] events;
    logic [alf_pkg::INT_W-1:0] clr;
    logic irq_reg;
    logic [31:0] rdata_reg;

    always_comb begin
        events = '0;
        events[alf_pkg::EV_THR_HIGH] = (occ_next >= thr_high_val) & ~thr_high_reg;
        events[alf_pkg::EV_THR_LOW] = (occ_next <= thr_low_val) & ~thr_low_reg;
        events[alf_pkg::EV_WR_STALL] = s_valid & ~s_ready_reg & run_n;
        events[alf_pkg::EV_DRAINED] = (occ_reg != '0) && (occ_next == '0);
    end

    assign clr = (bus_req.wr && bus_req.addr == alf_pkg::REG_INT_STATUS) ?
        bus_req.wdata[alf_pkg::INT_W-1:0] : '0;
    // A new event beats a write-one-to-clear in the same cycle
    assign int_status_next = (int_status_reg & ~clr) | events;
    assign int_mask_next = (bus_req.wr && bus_req.addr == alf_pkg::REG_INT_MASK) ?
        bus_req.wdata[alf_pkg::INT_W-1:0] : int_mask_reg;

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            int_status_reg <= alf_pkg::INT_STATUS_RST;
            int_mask_reg <= alf_pkg::INT_MASK_RST;
            irq_reg <= 1'b0;
        end else begin
            int_status_reg <= int_status_next;
            int_mask_reg <= int_mask_next;
            irq_reg <= |(int_status_next & int_mask_next);
        end
    end

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (bus_req.rd) begin
                case (bus_req.addr)
                    alf_pkg::REG_STATUS: begin
                        rdata_reg[alf_pkg::STAT_READY_BIT] <= s_ready_reg;
                        rdata_reg[alf_pkg::STAT_VALID_BIT] <= m_valid_reg;
                        rdata_reg[alf_pkg::STAT_THR_HIGH_BIT] <= thr_high_reg;
                        rdata_reg[alf_pkg::STAT_THR_LOW_BIT] <= thr_low_reg;
                        rdata_reg[alf_pkg::STAT_OCC_LSB +: OCC_W] <= occ_reg;
                    end
                    alf_pkg::REG_INT_STATUS: begin
                        rdata_reg[alf_pkg::INT_W-1:0] <= int_status_reg;
                    end
                    alf_pkg::REG_INT_MASK: begin
                        rdata_reg[alf_pkg::INT_W-1:0] <= int_mask_reg;
                    end
                    default: begin
                        rdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    assign bus_rdata = rdata_reg;
    assign irq = irq_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] in_cnt_reg;
    logic [31:0] out_cnt_reg;

    always_ff @(posedge clock or negedge run_n) begin
        if (!run_n) begin
            in_cnt_reg <= '0;
            out_cnt_reg <= '0;
        end else begin
            in_cnt_reg <= in_cnt_reg + 32'(push);
            out_cnt_reg <= out_cnt_reg + 32'(take);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!run_n);

    if (MODE != alf_pkg::ALF_PASS_THROUGH) begin : g_chk
        ready_space_a: assert property ((!s_ready_reg && $past(run_n)) |-> mem_cnt_reg == MEM_FULL)
            else $error("write ready low with space left");
        valid_data_a: assert property ((!m_valid_reg && mem_cnt_reg != '0) |=> m_valid_reg)
            else $error("read valid low with data stored");
        hold_stall_a: assert property ((m_valid_reg && !m_ready) |=> m_valid_reg && $stable(m_word_reg))
            else $error("output changed while stalled");
        look_ahead_a: assert property ((push && occ_reg == '0) |-> ##[1:2] m_valid_reg)
            else $error("stored word did not fall through");
        order_count_a: assert property (in_cnt_reg - out_cnt_reg == 32'(occ_reg))
            else $error("accepted and delivered words disagree");
        occ_step_a: assert property (occ_reg == $past(occ_reg) + OCC_W'($past(push)) - OCC_W'($past(take)))
            else $error("occupancy step wrong");
        thr_flag_a: assert property (thr_high_reg == (occ_reg >= $past(thr_high_val)))
            else $error("threshold high flag wrong");
        reset_quiet_a: assert property (disable iff (1'b0) !run_n |-> !s_ready_reg && !m_valid_reg)
            else $error("handshake active during reset");
        irq_level_a: assert property (irq_reg == |(int_status_reg & int_mask_reg))
            else $error("interrupt level disagrees with status");
        fill_c: cover property (!s_ready_reg ##1 take);
        both_c: cover property (push && take);
        drain_c: cover property (events[alf_pkg::EV_DRAINED] ##1 irq_reg);
    end

endmodule : alf_stream_fifo
`default_nettype wire

// ---- tb/alf_stream_partner.sv ----
// Upstream source and downstream sink model for the stream buffer
`timescale 1ns/10ps
`default_nettype none
module alf_stream_partner #(
    parameter int DATA_W = 32
) (
    input wire logic clock,
    input wire logic stall,
    output logic s_valid,
    input wire logic s_ready,
    output logic [DATA_W-1:0] s_data,
    output alf_pkg::alf_side_s s_side,
    input wire logic m_valid,
    output logic m_ready,
    input wire logic [DATA_W-1:0] m_data,
    input wire alf_pkg::alf_side_s m_side
);
    typedef logic [DATA_W+alf_pkg::SIDE_W-1:0] alf_word_t;
    alf_word_t tx_q[$];
    alf_word_t rx_q[$];

    initial begin
        s_valid = 1'b0;
        {s_side, s_data} = '0;
        m_ready = 1'b0;
    end

    always @(posedge clock) begin
        if (s_valid && s_ready) begin
            tx_q.delete(0);
        end
        if (tx_q.size() > 0) begin
            s_valid <= 1'b1;
            {s_side, s_data} <= tx_q[0];
        end else begin
            s_valid <= 1'b0;
            // Idle bus toggles so a stale word never looks valid
            {s_side, s_data} <= ~{s_side, s_data};
        end
    end

    always @(posedge clock) begin
        if (m_valid && m_ready) begin
            rx_q.push_back({m_side, m_data});
        end
        m_ready <= !stall;
    end
endmodule : alf_stream_partner
`default_nettype wire

// ---- tb/alf_stream_fifo_test.sv ----
// Self-checking testbench for the look-ahead stream buffer
`timescale 1ns/10ps
`default_nettype none
module alf_stream_fifo_test;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    localparam int DW = 32;
    localparam int DEPTH = 4;
    localparam int THR_H = 4;
    localparam int THR_L = 1;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    typedef logic [DW+alf_pkg::SIDE_W-1:0] alf_word_t;
    logic clock;
    logic arst_n;
    logic stall;
    logic s_valid;
    logic s_ready;
    logic [DW-1:0] s_data;
    alf_pkg::alf_side_s s_side;
    logic m_valid;
    logic m_ready;
    logic [DW-1:0] m_data;
    alf_pkg::alf_side_s m_side;
    logic thr_hi;
    logic thr_lo;
    logic q_valid;
    logic q_ready;
    logic [DW-1:0] q_data;
    alf_pkg::alf_side_s q_side;
    logic pt_hi;
    logic pt_lo;
    alf_pkg::alf_bus_req_s bus_req;
    logic [31:0] bus_rdata;
    logic irq;
    int n_mismatch;
    int cmp_count;

    alf_stream_fifo #(.DATA_W(DW), .DEPTH(DEPTH), .MODE(alf_pkg::ALF_FULL_BUFFER),
        .THR_SRC(alf_pkg::ALF_THR_CONST), .THR_HIGH_C(THR_H), .THR_LOW_C(THR_L)) DUT (
        .clock(clock), .arst_n(arst_n), .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
        .s_side(s_side), .m_valid(q_valid), .m_ready(q_ready), .m_data(q_data), .m_side(q_side),
        .thr_high_in('0), .thr_low_in('0), .threshold_high_flag(thr_hi), .threshold_low_flag(thr_lo),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq));

    // Pass-through stage on the read path, thresholds from ports
    alf_stream_fifo #(.DATA_W(DW), .DEPTH(DEPTH), .MODE(alf_pkg::ALF_PASS_THROUGH),
        .THR_SRC(alf_pkg::ALF_THR_PORT)) DUT_PASS (
        .clock(clock), .arst_n(arst_n), .s_valid(q_valid), .s_ready(q_ready), .s_data(q_data),
        .s_side(q_side), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_side(m_side),
        .thr_high_in(3'h0), .thr_low_in(3'h0), .threshold_high_flag(pt_hi), .threshold_low_flag(pt_lo),
        .bus_req('0), .bus_rdata(), .irq());

    alf_stream_partner #(.DATA_W(DW)) P (
        .clock(clock), .stall(stall), .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
        .s_side(s_side), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .m_side(m_side));

    initial clock = 1'b0;
    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg

    task chk_word(input string name, input alf_word_t exp, input alf_word_t got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    // One idle cycle after each strobe keeps every drive single per step
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus_req <= '0;
        @(posedge clock);
    endtask : bus_wr

    task bus_rd(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock);
        bus_req <= '0;
        #1;
        chk_reg(name, exp, bus_rdata & m);
        @(posedge clock);
    endtask : bus_rd

    function automatic alf_word_t mk(input int i);
        return {(i % 4) == 3, 8'(i * 37), 32'hC0DE0000 + 32'(i)};
    endfunction : mk

    task push(input int first, input int count);
        for (int i = first; i < first + count; i++) begin
            P.tx_q.push_back(mk(i));
        end
    endtask : push

    task wait_rx(input int n);
        for (int k = 0; k < 60 && P.rx_q.size() < n; k++) begin
            @(posedge clock);
        end
        chk_reg("words received", 32'(n), 32'(P.rx_q.size()));
    endtask : wait_rx

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        arst_n = 1'b0;
        stall = 1'b1;
        bus_req = '0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        bus_rd("status idle", alf_pkg::REG_STATUS, ALL, 32'h9);
        bus_rd("mask reset", alf_pkg::REG_INT_MASK, ALL, 32'h0);
        bus_rd("unmapped", 8'h0C, ALL, 32'h0);
        chk_reg("port thr high", 32'h1, 32'(pt_hi));
        chk_reg("port thr low", 32'h1, 32'(pt_lo));
        // Sink stalled: five words fit, the rest are refused
        push(0, 7);
        repeat (12) @(posedge clock);
        bus_rd("status full", alf_pkg::REG_STATUS, ALL, 32'h506);
        bus_rd("events full", alf_pkg::REG_INT_STATUS, 32'h5, 32'h5);
        bus_wr(alf_pkg::REG_INT_MASK, 32'h4);
        #1;
        chk_reg("irq set", 32'h1, 32'(irq));
        chk_reg("thr high pin", 32'h1, 32'(thr_hi));
        chk_reg("thr low pin", 32'h0, 32'(thr_lo));
        @(posedge clock);
        stall <= 1'b0;
        wait_rx(7);
        bus_rd("status drained", alf_pkg::REG_STATUS, ALL, 32'h9);
        bus_rd("drain event", alf_pkg::REG_INT_STATUS, 32'h8, 32'h8);
        bus_wr(alf_pkg::REG_INT_STATUS, 32'hF);
        bus_rd("events cleared", alf_pkg::REG_INT_STATUS, 32'hF, 32'h0);
        #1;
        chk_reg("irq clear", 32'h0, 32'(irq));
        chk_reg("thr high clear", 32'h0, 32'(thr_hi));
        chk_reg("thr low set", 32'h1, 32'(thr_lo));
        @(posedge clock);
        // Running sink: back-to-back words
        push(7, 8);
        wait_rx(15);
        chk_reg("received", 32'd15, 32'(P.rx_q.size()));
        for (int i = 0; i < 15; i++) begin
            chk_word("word", mk(i), P.rx_q[i]);
        end
        // Reset while words are stored
        stall <= 1'b1;
        repeat (2) @(posedge clock);
        push(15, 3);
        repeat (10) @(posedge clock);
        bus_rd("status part", alf_pkg::REG_STATUS, ALL, 32'h303);
        arst_n <= 1'b0;
        @(posedge clock);
        #1;
        chk_reg("ready in reset", 32'h0, 32'(s_ready));
        chk_reg("valid in reset", 32'h0, 32'(m_valid));
        chk_reg("stage valid in reset", 32'h0, 32'(q_valid));
        @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk_reg("valid after reset", 32'h0, 32'(m_valid));
        @(posedge clock);
        bus_rd("status reset", alf_pkg::REG_STATUS, ALL, 32'h9);
        bus_rd("mask again", alf_pkg::REG_INT_MASK, ALL, 32'h0);
        chk_reg("no stray words", 32'd15, 32'(P.rx_q.size()));
        give_verdict();
    end
endmodule : alf_stream_fifo_test
`default_nettype wire
